// ### pcs_afe_model.sv
// Behavioural receive chain: precondition, connect window and converter codes
`timescale 1ns/1ps
module pcs_afe_model (
   // Clock
   input  wire logic        i_mclk,
   // Timing and data towards the sequencer
   output logic             o_precon,
   output logic             o_mod,
   output logic             o_done,
   output logic      [13:0] o_data
);
   initial begin
      o_precon = 1'b0;
      o_mod = 1'b0;
      o_done = 1'b0;
      o_data = 14'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Precondition window of n cycles
   task automatic precondition(input int n);
      @(posedge i_mclk);
      #1 o_precon = 1'b1;
      repeat (n) @(posedge i_mclk);
      #1 o_precon = 1'b0;
   endtask : precondition
   // One connect window then one converted pulse; codes carry no converter
   // offset, as chopping needs, and the stale code is inverted
   task automatic convert(input logic [13:0] code, input int gap);
      repeat (gap) @(posedge i_mclk);
      #1 o_mod = 1'b1;
      @(posedge i_mclk);
      #1 o_mod = 1'b0;
      o_done = 1'b1;
      o_data = code;
      @(posedge i_mclk);
      #1 o_done = 1'b0;
      o_data = ~code;
   endtask : convert
endmodule : pcs_afe_model

// ### pcs_pattern_bank.sv
// Per-slot pattern registers with address decode and read-back
`timescale 1ns/1ps
module pcs_pattern_bank
   import pcs_pkg::*;
#(
   parameter int NUM_SLOTS = PCS_NUM_SLOTS
) (
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // Register access
   input  wire logic        i_wr,
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   output logic      [15:0] o_rdata,
   // Pattern of the slot being sequenced
   input  wire logic [3:0]  i_slot,
   output logic      [15:0] o_sel_pattern
);
   typedef struct packed {
      logic [NUM_SLOTS-1:0][15:0] pat;
      logic [15:0]                rdata;
   } pcs_bank_s;

   pcs_bank_s              bank_ff;
   pcs_bank_s              nxt_bank;
   logic [NUM_SLOTS-1:0]   w_hit;

   ////////////////////////////////////////////////////////////////////////////
   // One address comparator per slot, each copy a fixed stride above the last
   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++) begin : g_dec
         assign w_hit[g] = (i_addr == 16'(PCS_PAT_BASE_ADDR + g * PCS_SLOT_STRIDE));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Writes land in the decoded slot; unmapped reads return zero
   always_comb begin
      nxt_bank       = bank_ff;
      nxt_bank.rdata = 16'h0000;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         if (w_hit[s]) begin
            nxt_bank.rdata = bank_ff.pat[s];
            if (i_wr) begin
               nxt_bank.pat[s] = i_wdata;
            end
         end
      end
   end

   // Register the whole state
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         bank_ff.pat   <= {NUM_SLOTS{PCS_PAT_RESET}};
         bank_ff.rdata <= 16'h0000;
      end else begin
         bank_ff <= nxt_bank;
      end
   end

   assign o_rdata       = bank_ff.rdata;
   // Out-of-range slot numbers see an all-zero pattern
   assign o_sel_pattern = (32'(i_slot) < NUM_SLOTS) ? bank_ff.pat[i_slot] : 16'h0000;
endmodule : pcs_pattern_bank

// ### pcs_pkg.sv
// Package with addresses, field positions, reset values and modes for the pulse sequencer
package pcs_pkg;
   // Pattern register of the first time slot and the stride to each later slot
   localparam logic [15:0] PCS_PAT_BASE_ADDR   = 16'h010D;
   localparam logic [15:0] PCS_SLOT_STRIDE     = 16'h0020;
   localparam int          PCS_NUM_SLOTS       = 12;
   localparam logic [15:0] PCS_PAT_RESET       = 16'h0000;
   // Field positions inside the pattern register
   localparam int          PCS_REV_LSB         = 0;
   localparam int          PCS_NEG_LSB         = 4;
   localparam int          PCS_GROUP_LEN       = 4;
   // Midscale offset added to the final result
   localparam logic [15:0] PCS_MIDSCALE_CODES  = 16'h0800;
   // Connection modulation types
   localparam logic [1:0]  PCS_MOD_CONTINUOUS  = 2'h0;
   localparam logic [1:0]  PCS_MOD_FLOAT       = 2'h1;
   localparam logic [1:0]  PCS_MOD_PRECON      = 2'h2;
   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      PCS_ST_IDLE = 3'b001,
      PCS_ST_RUN  = 3'b010,
      PCS_ST_DONE = 3'b100
   } pcs_state_e;
endpackage : pcs_pkg

// ### pcs_pulse_chop_seq.sv
// Pulse chopping, accumulation and input-connection sequencer for one receive path
// Operation
// - Reverse bit swaps integrator phase order per pulse
// - Negate bit subtracts pulse result, else adds
// - Patterns repeat over every group of four
// - Midscale bit adds 2048 to final result
// - Pattern register copies per slot at stride
// - Type zero: continuous connection after precondition
// - Type one: connect only during pulse, float
// - Type two: connect in pulse, precondition between
// - Float: precondition, float, then reconnect to integrate
// - Float mode bypasses the bandpass filter
// - Float integrates charge in negative phase
// - Single integration: repeat count is pulse total
// - Exactly one result write per sample
`timescale 1ns/1ps
module pcs_pulse_chop_seq
   import pcs_pkg::*;
#(
   parameter int DATA_W    = 14,
   parameter int ACC_W     = 24,
   parameter int NUM_SLOTS = PCS_NUM_SLOTS
) (
   // Clock and reset
   input  wire logic              i_mclk,
   input  wire logic              i_rst_n,
   // Register access port
   input  wire logic              i_reg_wr,
   input  wire logic [15:0]       i_reg_addr,
   input  wire logic [15:0]       i_reg_wdata,
   output logic      [15:0]       o_reg_rdata,
   // Per-sample configuration of the active slot
   input  wire logic [3:0]        i_slot,
   input  wire logic [7:0]        i_num_int,
   input  wire logic [7:0]        i_num_repeat,
   input  wire logic [1:0]        i_connect_modulation_type,
   input  wire logic              i_midscale_add_bit,
   // Timing events from the slot timer
   input  wire logic              i_sample_start,
   input  wire logic              i_precon_active,
   input  wire logic              i_mod_pulse,
   input  wire logic              i_pulse_done,
   input  wire logic [DATA_W-1:0] i_pulse_data,
   // Analog path control
   output logic                   o_integ_reverse,
   output logic                   o_amp_connect,
   output logic                   o_precon_drive,
   output logic                   o_bpf_bypass,
   output logic                   o_integ_neg_only,
   // Sample result
   output logic [ACC_W-1:0]       o_result,
   output logic                   o_result_valid,
   output logic                   o_busy
);
   typedef struct packed {
      pcs_state_e        st;
      logic [1:0]        pos;
      logic [15:0]       cnt;
      logic [15:0]       total;
      logic [7:0]        pat;
      logic [ACC_W-1:0]  acc;
      logic [ACC_W-1:0]  result;
      logic              valid;
      logic              reverse;
      logic              connect;
      logic              precon;
      logic              bypass;
      logic              neg_only;
      logic              busy;
   } pcs_seq_s;

   pcs_seq_s          seq_ff;
   pcs_seq_s          nxt_seq;
   logic [15:0]       w_sel_pattern;
   logic [ACC_W-1:0]  w_data_ext;
   logic [15:0]       w_total;
   logic [3:0]        w_rev;
   logic [3:0]        w_neg;

   ////////////////////////////////////////////////////////////////////////////
   // Pattern registers, one copy per time slot
   pcs_pattern_bank #(
      .NUM_SLOTS     (NUM_SLOTS)
   ) u_bank (
      .i_mclk        (i_mclk),
      .i_rst_n       (i_rst_n),
      .i_wr          (i_reg_wr),
      .i_addr        (i_reg_addr),
      .i_wdata       (i_reg_wdata),
      .o_rdata       (o_reg_rdata),
      .i_slot        (i_slot),
      .o_sel_pattern (w_sel_pattern)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pulse total and field split; the pattern is frozen at sample start so a
   // register write mid-sample cannot break group alignment
   assign w_total    = (i_num_int == 8'h01) ? {8'h00, i_num_repeat}
                     : 16'(16'(i_num_repeat) * 16'(i_num_int));
   // Converter codes are unsigned; zero extension keeps them positive, but
   // very long samples of full-scale codes can wrap the signed accumulator
   assign w_data_ext = ACC_W'(i_pulse_data);
   assign w_rev      = seq_ff.pat[PCS_REV_LSB +: PCS_GROUP_LEN];
   assign w_neg      = seq_ff.pat[PCS_NEG_LSB +: PCS_GROUP_LEN];

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      nxt_seq       = seq_ff;
      nxt_seq.valid = 1'b0;

      // Input connection per modulation type; an unused code behaves as type 0
      // The connection follows its inputs one cycle late and is not tied to
      // the sample state, so the slot timer alone decides the connect windows
      unique case (i_connect_modulation_type)
         PCS_MOD_FLOAT: begin
            nxt_seq.precon   = i_precon_active;
            nxt_seq.connect  = !i_precon_active && i_mod_pulse;
            nxt_seq.bypass   = 1'b1;
            nxt_seq.neg_only = 1'b1;
         end
         PCS_MOD_PRECON: begin
            nxt_seq.precon   = i_precon_active || !i_mod_pulse;
            nxt_seq.connect  = !i_precon_active && i_mod_pulse;
            nxt_seq.bypass   = 1'b0;
            nxt_seq.neg_only = 1'b0;
         end
         default: begin
            nxt_seq.precon   = i_precon_active;
            nxt_seq.connect  = !i_precon_active;
            nxt_seq.bypass   = 1'b0;
            nxt_seq.neg_only = 1'b0;
         end
      endcase

      // Sample sequencing
      unique case (seq_ff.st)
         PCS_ST_IDLE: begin
            if (i_sample_start) begin
               nxt_seq.pat   = w_sel_pattern[7:0];
               nxt_seq.total = w_total;
               nxt_seq.pos   = 2'h0;
               nxt_seq.cnt   = 16'h0000;
               nxt_seq.acc   = '0;
               nxt_seq.busy  = 1'b1;
               nxt_seq.st    = (w_total == 16'h0000) ? PCS_ST_DONE : PCS_ST_RUN;
            end
         end
         PCS_ST_RUN: begin
            if (i_pulse_done) begin
               if (w_neg[seq_ff.pos]) begin
                  nxt_seq.acc = seq_ff.acc - w_data_ext;
               end else begin
                  nxt_seq.acc = seq_ff.acc + w_data_ext;
               end
               nxt_seq.pos = seq_ff.pos + 2'h1;
               nxt_seq.cnt = seq_ff.cnt + 16'h0001;
               if (seq_ff.cnt + 16'h0001 == seq_ff.total) begin
                  nxt_seq.st = PCS_ST_DONE;
               end
            end
         end
         PCS_ST_DONE: begin
            // Single write of the final value, midscale added once at the end
            // Adding it here rather than at start keeps the running sum free of it
            nxt_seq.result = i_midscale_add_bit
                           ? seq_ff.acc + ACC_W'(PCS_MIDSCALE_CODES)
                           : seq_ff.acc;
            nxt_seq.valid  = 1'b1;
            nxt_seq.busy   = 1'b0;
            nxt_seq.st     = PCS_ST_IDLE;
         end
         default: begin
            nxt_seq.st   = PCS_ST_IDLE;
            nxt_seq.busy = 1'b0;
         end
      endcase

      // Integrator phase order for the upcoming pulse; taken from the next
      // state so the order is in place on the edge the position moves, and
      // forced low outside a sample so an idle integrator keeps its default
      nxt_seq.reverse = (nxt_seq.st == PCS_ST_RUN)
                      && nxt_seq.pat[PCS_REV_LSB + 32'(nxt_seq.pos)];
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         seq_ff.st       <= PCS_ST_IDLE;
         seq_ff.pos      <= 2'h0;
         seq_ff.cnt      <= 16'h0000;
         seq_ff.total    <= 16'h0000;
         seq_ff.pat      <= 8'h00;
         seq_ff.acc      <= '0;
         seq_ff.result   <= '0;
         seq_ff.valid    <= 1'b0;
         seq_ff.reverse  <= 1'b0;
         seq_ff.connect  <= 1'b0;
         seq_ff.precon   <= 1'b0;
         seq_ff.bypass   <= 1'b0;
         seq_ff.neg_only <= 1'b0;
         seq_ff.busy     <= 1'b0;
      end else begin
         seq_ff <= nxt_seq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign o_integ_reverse  = seq_ff.reverse;
   assign o_amp_connect    = seq_ff.connect;
   assign o_precon_drive   = seq_ff.precon;
   assign o_bpf_bypass     = seq_ff.bypass;
   assign o_integ_neg_only = seq_ff.neg_only;
   assign o_result         = seq_ff.result;
   assign o_result_valid   = seq_ff.valid;
   assign o_busy           = seq_ff.busy;
endmodule : pcs_pulse_chop_seq

// ### pcs_seq_props.sv
// Checker for the pulse sequencer outputs
`timescale 1ns/1ps
module pcs_seq_props
   import pcs_pkg::*;
(
   // Watched ports
   input wire logic        i_mclk,
   input wire logic        i_rst_n,
   input wire logic [15:0] i_reg_addr,
   input wire logic [15:0] o_reg_rdata,
   input wire logic [7:0]  i_num_repeat,
   input wire logic [1:0]  i_connect_modulation_type,
   input wire logic        i_sample_start,
   input wire logic        i_precon_active,
   input wire logic        i_mod_pulse,
   input wire logic        o_amp_connect,
   input wire logic        o_precon_drive,
   input wire logic        o_bpf_bypass,
   input wire logic        o_integ_neg_only,
   input wire logic        o_result_valid,
   input wire logic        o_busy
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   logic [1:0] mt;
   ////////////////////////////////////////////////////////////////////////////////
   // Mode decoded once; past values guard the first edge after reset
   assign mt = i_connect_modulation_type;
   valid_spacing_a: assert property (o_result_valid |-> !o_busy ##1 !o_result_valid[*2])
      else $error("result valid not a lone pulse");
   start_busy_a: assert property (i_sample_start && !o_busy && !o_result_valid
      && i_num_repeat != 8'h00 |=> o_busy) else $error("start not taken");
   cont_connect_a: assert property ($past(i_rst_n) && $past(mt) == PCS_MOD_CONTINUOUS
      |-> o_amp_connect == !$past(i_precon_active)) else $error("type zero connect");
   float_connect_a: assert property ($past(i_rst_n) && $past(mt) == PCS_MOD_FLOAT
      |-> o_amp_connect == $past(!i_precon_active && i_mod_pulse)
      && o_precon_drive == $past(i_precon_active)) else $error("float connect");
   precon_between_a: assert property ($past(i_rst_n) && $past(mt) == PCS_MOD_PRECON
      |-> o_amp_connect == $past(!i_precon_active && i_mod_pulse)
      && o_precon_drive == $past(i_precon_active || !i_mod_pulse)) else $error("type two");
   bypass_float_a: assert property ($past(i_rst_n)
      |-> o_bpf_bypass == ($past(mt) == PCS_MOD_FLOAT)) else $error("filter bypass");
   neg_only_a: assert property ($past(i_rst_n)
      |-> o_integ_neg_only == ($past(mt) == PCS_MOD_FLOAT)) else $error("negative phase only");
   unmapped_read_a: assert property ($past(i_rst_n) && $past(i_reg_addr) == 16'h010E
      |-> o_reg_rdata == 16'h0000) else $error("unmapped read");
   cover property (o_result_valid);
   cover property ($past(mt) == PCS_MOD_FLOAT && o_amp_connect);
   cover property ($past(mt) == PCS_MOD_PRECON && o_precon_drive);
endmodule : pcs_seq_props

// ### test_pulse_chop_connect_sequencer.sv
// Self-checking bench for the pulse sequencer
`timescale 1ns/1ps
module test_pulse_chop_connect_sequencer
   import pcs_pkg::*;
;
   logic clk, rst_n, wr, mid, start, pre, mod, done, rev, conn, pdrv, byp, neg, valid, busy;
   logic [15:0] addr, wdata, rdata;
   logic [7:0]  nint, nrep;
   logic [3:0]  slot;
   logic [1:0]  mtype;
   logic [13:0] pdata;
   logic [23:0] res;
   int          checks = 0, mismatches = 0, cycles = 0;
   pcs_pulse_chop_seq i_pcs_pulse_chop_seq (.i_mclk(clk), .i_rst_n(rst_n), .i_reg_wr(wr),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_slot(slot),
      .i_num_int(nint), .i_num_repeat(nrep), .i_connect_modulation_type(mtype),
      .i_midscale_add_bit(mid), .i_sample_start(start), .i_precon_active(pre),
      .i_mod_pulse(mod), .i_pulse_done(done), .i_pulse_data(pdata), .o_integ_reverse(rev),
      .o_amp_connect(conn), .o_precon_drive(pdrv), .o_bpf_bypass(byp),
      .o_integ_neg_only(neg), .o_result(res), .o_result_valid(valid), .o_busy(busy));
   pcs_afe_model i_pcs_afe_model (.i_mclk(clk), .o_precon(pre), .o_mod(mod), .o_done(done),
      .o_data(pdata));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // Register write strobe lasts exactly one edge; an idle edge follows so
   // back-to-back calls never retoggle the strobe in one time step
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1 wr = 1'b0;
      @(posedge clk);
      #1;
   endtask : wr_reg
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      addr = a;
      @(posedge clk);
      #1 check("rdata", rdata, exp);
   endtask : rd_chk
   ////////////////////////////////////////////////////////////////////////////////
   // Slot copies at the stride, reset value, unmapped places
   task automatic test_regs();
      rd_chk(16'h012D, PCS_PAT_RESET);
      wr_reg(16'h012D, 16'hC3AA);
      wr_reg(16'h026D, 16'h005C);
      wr_reg(16'h028D, 16'hFFFF);
      rd_chk(16'h012D, 16'hC3AA);
      rd_chk(16'h026D, 16'h005C);
      rd_chk(16'h028D, 16'h0000);
      rd_chk(16'h010E, 16'h0000);
      rd_chk(16'h010D, 16'h0000);
   endtask : test_regs
   // Expected sum built pulse by pulse from the pattern; codes climb from base
   task automatic run_sample(input logic [3:0] sl, input logic [7:0] ni, input logic [7:0] nr,
      input logic [7:0] pat, input logic md, input logic [13:0] base);
      int total, acc, k, w;
      total = (ni == 8'h01) ? int'(nr) : int'(nr) * int'(ni);
      acc = md ? 2048 : 0;
      slot = sl;
      nint = ni;
      nrep = nr;
      mid = md;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      check("busy", busy, 1'b1);
      for (k = 0; k < total; k++) begin
         if (k > 0) begin
            @(posedge clk);
            #1;
         end
         check("reverse", rev, pat[k % 4]);
         acc = pat[4 + k % 4] ? acc - (int'(base) + k) : acc + (int'(base) + k);
         i_pcs_afe_model.convert(base + 14'(k), 1);
      end
      w = 0;
      while (valid !== 1'b1 && w < 20) begin
         @(posedge clk);
         #1 w++;
      end
      check("valid", valid, 1'b1);
      check("busy_end", busy, 1'b0);
      check("result", res, 24'(acc));
      @(posedge clk);
      #1 check("valid_end", valid, 1'b0);
   endtask : run_sample
   // Every connection type, the unused code too, in precondition, pulse and gap
   task automatic test_connect();
      for (int t = 0; t < 4; t++) begin
         mtype = 2'(t);
         i_pcs_afe_model.precondition(3);
         check("precon_drive", pdrv, 1'b1);
         check("connect_pre", conn, 1'b0);
         fork
            i_pcs_afe_model.convert(14'h0000, 2);
            begin
               repeat (3) @(posedge clk);
               #1 check("connect_in", conn, 1'b1);
               check("precon_in", pdrv, 1'b0);
            end
         join
         check("connect_gap", conn, t == 0 || t == 3);
         check("precon_gap", pdrv, t == 2);
         check("bypass", byp, t == 1);
         check("neg_only", neg, t == 1);
      end
   endtask : test_connect
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   // Main sequence; six pulses leave the group mid-way to expose a stale position
   initial begin
      {rst_n, wr, mid, start, addr, wdata, nint, nrep, slot, mtype} = '0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      test_regs();
      run_sample(4'h1, 8'h01, 8'h08, 8'hAA, 1'b0, 14'h0100);
      run_sample(4'hB, 8'h02, 8'h03, 8'h5C, 1'b1, 14'h2000);
      run_sample(4'hB, 8'h01, 8'h04, 8'h5C, 1'b0, 14'h0010);
      test_connect();
      complete_run();
   end
endmodule : test_pulse_chop_connect_sequencer
bind pcs_pulse_chop_seq pcs_seq_props i_pcs_seq_props (.i_mclk, .i_rst_n, .i_reg_addr,
   .o_reg_rdata, .i_num_repeat, .i_connect_modulation_type, .i_sample_start,
   .i_precon_active, .i_mod_pulse, .o_amp_connect, .o_precon_drive, .o_bpf_bypass,
   .o_integ_neg_only, .o_result_valid, .o_busy);
